// ### logic/ovf_pkg.sv
// Package with the constants and types of the over-voltage fault response block.
package ovf_pkg;

	localparam logic [7:0] ADDR_ACTION_CFG = 8'h41;
	localparam logic [7:0] ACTION_CFG_RST  = 8'h80;

	localparam int RESP_MSB  = 7;
	localparam int RESP_LSB  = 6;
	localparam int RETRY_MSB = 5;
	localparam int RETRY_LSB = 3;
	localparam int DELAY_MSB = 2;
	localparam int DELAY_LSB = 0;

	localparam logic [1:0] RESP_IGNORE  = 2'h0;
	localparam logic [1:0] RESP_DELAYED = 2'h1;
	localparam logic [1:0] RESP_RETRY   = 2'h2;
	localparam logic [1:0] RESP_HOLD    = 2'h3;

	localparam logic [2:0] RETRY_NONE    = 3'h0;
	localparam logic [2:0] RETRY_ENDLESS = 3'h7;

	typedef struct packed {
		logic [1:0] resp;
		logic [2:0] retries;
		logic [2:0] delay;
	} ovf_cfg_t;

	typedef enum logic [2:0] {
		ST_RUN     = 3'h0,
		ST_DELAY   = 3'h1,
		ST_OFFWAIT = 3'h3,
		ST_TRY     = 3'h2,
		ST_LATCHED = 3'h6,
		ST_HOLD    = 3'h7
	} ovf_state_t;

	// Each step of the delay code doubles the number of time units.
	function automatic logic [7:0] delay_units(input logic [2:0] code);
		delay_units = 8'h01 << code;
	endfunction

endpackage

// ### logic/ovf_delay_timer.sv
// Counts delay time units for the fault delay and the retry spacing.
`timescale 1ns/1ps
module ovf_delay_timer (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	// Control
	input  wire logic       i_start,
	input  wire logic [2:0] i_code,
	input  wire logic       i_tick,
	// Result
	output logic            o_done
);
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic       done_ff;
	logic       nxt_done;

	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_done = 1'b0;
		if (i_start) begin
			nxt_cnt = ovf_pkg::delay_units(i_code);
		end else if (i_tick && cnt_ff != 8'h00) begin
			nxt_cnt = cnt_ff - 8'h01;
			nxt_done = (cnt_ff == 8'h01);
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_ff  <= 8'h00;
			done_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end

	assign o_done = done_ff;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	AST_ONE_UNIT: assert property (
		(i_start && i_code == 3'h0) ##1 (i_tick && !i_start) |=> o_done)
		else $error("Delay code 0 did not expire after one unit.");
	AST_TWO_UNITS: assert property (
		(i_start && i_code == 3'h1) ##1 (i_tick && !i_start) |=> !o_done)
		else $error("Delay code 1 expired after only one unit.");

endmodule

// ### logic/ovf_fault_ctrl.sv
// Over-voltage fault response controller with its configuration register.
`timescale 1ns/1ps
module ovf_fault_ctrl (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// Register access
	input  wire logic        i_reg_wr,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	output logic      [7:0]  o_reg_rdata,
	// Fault clearing
	input  wire logic        i_clear_faults,
	input  wire logic        i_status_clr,
	// Operation control
	input  wire logic        i_ctrl_on,
	input  wire logic        i_ext_shutdown,
	// Measurement
	input  wire logic [15:0] i_vout,
	input  wire logic [15:0] i_ov_fault_threshold,
	input  wire logic        i_unit_tick,
	// Outputs
	output logic             o_out_en,
	output logic             o_ov_fault,
	output logic [2:0]       o_state
);
	ovf_pkg::ovf_cfg_t   cfg_ff;
	ovf_pkg::ovf_cfg_t   nxt_cfg;
	ovf_pkg::ovf_state_t st_ff;
	ovf_pkg::ovf_state_t nxt_st;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic       on_meta_ff;
	logic       on_ff;
	logic       flag_ff;
	logic       nxt_flag;
	logic       en_ff;
	logic       nxt_en;
	logic [2:0] left_ff;
	logic [2:0] nxt_left;
	logic       tmr_start;
	logic       tmr_done;
	logic       ov_now;
	logic       clr_any;
	logic       endless;

	assign ov_now  = i_vout > i_ov_fault_threshold;
	assign clr_any = i_clear_faults | i_status_clr;
	assign endless = cfg_ff.retries == ovf_pkg::RETRY_ENDLESS;

	// The control pin comes from outside; only the second stage is read.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			on_meta_ff <= 1'b0;
			on_ff      <= 1'b0;
		end else begin
			on_meta_ff <= i_ctrl_on;
			on_ff      <= on_meta_ff;
		end
	end

	always_comb begin
		nxt_cfg   = cfg_ff;
		nxt_rdata = 8'h00;
		if (i_reg_wr && i_reg_addr == ovf_pkg::ADDR_ACTION_CFG) begin
			nxt_cfg = ovf_pkg::ovf_cfg_t'(i_reg_wdata);
		end
		if (i_reg_addr == ovf_pkg::ADDR_ACTION_CFG) begin
			nxt_rdata = cfg_ff;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cfg_ff   <= ovf_pkg::ovf_cfg_t'(ovf_pkg::ACTION_CFG_RST);
			rdata_ff <= 8'h00;
		end else begin
			cfg_ff   <= nxt_cfg;
			rdata_ff <= nxt_rdata;
		end
	end

	// A new over-voltage event wins over a clear in the same cycle.
	always_comb begin
		nxt_flag = flag_ff;
		if (clr_any || !on_ff) begin
			nxt_flag = 1'b0;
		end
		if (ov_now) begin
			nxt_flag = 1'b1;
		end
	end

	// Response sequencer. Commanding the output off ends any sequence, so an
	// off-then-on cycle always restarts from a clean state.
	always_comb begin
		nxt_st    = st_ff;
		nxt_left  = left_ff;
		tmr_start = 1'b0;
		if (!on_ff) begin
			nxt_st = ovf_pkg::ST_RUN;
		end else if (i_ext_shutdown) begin
			nxt_st = ovf_pkg::ST_LATCHED;
		end else begin
			case (st_ff)
				ovf_pkg::ST_RUN: begin
					if (ov_now) begin
						case (cfg_ff.resp)
							ovf_pkg::RESP_IGNORE: nxt_st = ovf_pkg::ST_RUN;
							ovf_pkg::RESP_DELAYED: begin
								nxt_st    = ovf_pkg::ST_DELAY;
								tmr_start = 1'b1;
							end
							ovf_pkg::RESP_RETRY: begin
								tmr_start = 1'b1;
								nxt_left  = cfg_ff.retries;
								nxt_st    = (cfg_ff.retries == ovf_pkg::RETRY_NONE) ?
									ovf_pkg::ST_LATCHED : ovf_pkg::ST_OFFWAIT;
							end
							default: nxt_st = ovf_pkg::ST_HOLD;
						endcase
					end
				end
				ovf_pkg::ST_DELAY: begin
					if (tmr_done) begin
						if (ov_now) begin
							tmr_start = 1'b1;
							nxt_left  = cfg_ff.retries;
							nxt_st    = (cfg_ff.retries == ovf_pkg::RETRY_NONE) ?
								ovf_pkg::ST_LATCHED : ovf_pkg::ST_OFFWAIT;
						end else begin
							nxt_st = ovf_pkg::ST_RUN;
						end
					end
				end
				ovf_pkg::ST_OFFWAIT: begin
					if (tmr_done) begin
						tmr_start = 1'b1;
						nxt_st    = ovf_pkg::ST_TRY;
						if (!endless) begin
							nxt_left = left_ff - 3'h1;
						end
					end
				end
				ovf_pkg::ST_TRY: begin
					if (ov_now) begin
						if (left_ff == 3'h0 && !endless) begin
							nxt_st = ovf_pkg::ST_LATCHED;
						end else begin
							nxt_st = ovf_pkg::ST_OFFWAIT;
							// A spacing that ends in the very cycle of the failure would never
							// be seen in OFFWAIT, so a fresh one is started instead.
							tmr_start = tmr_done;
						end
					end else if (tmr_done) begin
						nxt_st = ovf_pkg::ST_RUN;
					end
				end
				ovf_pkg::ST_LATCHED: begin
					if (clr_any) begin
						nxt_st = ovf_pkg::ST_RUN;
					end
				end
				ovf_pkg::ST_HOLD: begin
					if (!ov_now) begin
						nxt_st = ovf_pkg::ST_RUN;
					end
				end
				default: nxt_st = ovf_pkg::ST_LATCHED;
			endcase
		end
		nxt_en = on_ff && (nxt_st == ovf_pkg::ST_RUN || nxt_st == ovf_pkg::ST_DELAY ||
			nxt_st == ovf_pkg::ST_TRY);
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff   <= ovf_pkg::ST_RUN;
			left_ff <= 3'h0;
			flag_ff <= 1'b0;
			en_ff   <= 1'b0;
		end else begin
			st_ff   <= nxt_st;
			left_ff <= nxt_left;
			flag_ff <= nxt_flag;
			en_ff   <= nxt_en;
		end
	end

	ovf_delay_timer u_timer (
		.i_clk   (i_clk),
		.i_rstn  (i_rstn),
		.i_start (tmr_start),
		.i_code  (cfg_ff.delay),
		.i_tick  (i_unit_tick),
		.o_done  (tmr_done)
	);

	assign o_reg_rdata = rdata_ff;
	assign o_out_en    = en_ff;
	assign o_ov_fault  = flag_ff;
	assign o_state     = st_ff;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	sequence s_live;
		on_ff && !i_ext_shutdown;
	endsequence

	AST_IGNORE_KEEPS_ON: assert property (
		(st_ff == ovf_pkg::ST_RUN && cfg_ff.resp == ovf_pkg::RESP_IGNORE) and s_live
		|=> o_out_en)
		else $error("Output dropped although the fault is ignored.");
	AST_DELAY_RUNS_ON: assert property (
		(st_ff == ovf_pkg::ST_RUN && ov_now && cfg_ff.resp == ovf_pkg::RESP_DELAYED) and s_live
		|=> o_out_en && st_ff == ovf_pkg::ST_DELAY)
		else $error("Delayed response did not keep running.");
	AST_DISABLE_NOW: assert property (
		(st_ff == ovf_pkg::ST_RUN && ov_now && cfg_ff.resp == ovf_pkg::RESP_RETRY)
		|=> !o_out_en)
		else $error("Output not disabled at once.");
	AST_HOLD_RESUMES: assert property (
		(st_ff == ovf_pkg::ST_HOLD && !ov_now) and s_live |=> o_out_en)
		else $error("Output did not resume after fault went away.");
	AST_CLEAR_UNLATCH: assert property (
		(st_ff == ovf_pkg::ST_LATCHED && i_clear_faults) and s_live
		|=> st_ff == ovf_pkg::ST_RUN)
		else $error("Clear did not release the latched fault.");
	AST_LATCH_STAYS_OFF: assert property (
		(st_ff == ovf_pkg::ST_LATCHED && !clr_any) |=> !o_out_en)
		else $error("Latched fault let the output on.");
	AST_LAST_TRY_LATCH: assert property (
		(st_ff == ovf_pkg::ST_TRY && ov_now && left_ff == 3'h0 && !endless) and s_live
		|=> st_ff == ovf_pkg::ST_LATCHED && !o_out_en)
		else $error("Failed last attempt did not latch off.");
	AST_ENDLESS_RETRY: assert property (
		(st_ff == ovf_pkg::ST_TRY && ov_now && endless) and s_live
		|=> st_ff == ovf_pkg::ST_OFFWAIT)
		else $error("Continuous retry stopped.");
	AST_OFF_STOPS: assert property (
		!on_ff |=> st_ff == ovf_pkg::ST_RUN && !o_out_en)
		else $error("Command off did not stop the sequence.");
	AST_EXT_SHUTDOWN: assert property (
		(on_ff && i_ext_shutdown) |=> st_ff == ovf_pkg::ST_LATCHED && !o_out_en)
		else $error("Forced shutdown did not latch the output off.");
	AST_FLAG_SET: assert property (
		ov_now |=> o_ov_fault)
		else $error("Over-voltage did not set the fault flag.");

endmodule

// ### bench/ovf_host_model.sv
// Host model: register writes and reads, fault clear pulses, time-unit tick.
`timescale 1ns/1ps
module ovf_host_model #(parameter int TICK_DIV = 2) (
	// Clock
	input  wire logic i_clk,
	// Register access
	output logic       o_wr,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	// Fault clearing and time base
	output logic       o_clear_faults,
	output logic       o_status_clr,
	output logic       o_tick
);
	int tick_cnt = 0;
	initial begin
		{o_wr, o_addr, o_wdata, o_clear_faults, o_status_clr, o_tick} = '0;
	end
	// A single-cycle tick keeps the unit count exact.
	always @(negedge i_clk) begin
		tick_cnt = (tick_cnt + 1) % TICK_DIV;
		o_tick <= (tick_cnt == 0);
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		{o_wr, o_addr, o_wdata} <= {1'b1, a, d};
		@(negedge i_clk);
		o_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge i_clk);
		o_addr <= a;
		@(negedge i_clk);
	endtask
	task automatic clr(input bit by_status);
		@(negedge i_clk);
		if (by_status)
			o_status_clr <= 1'b1;
		else
			o_clear_faults <= 1'b1;
		@(negedge i_clk);
		{o_clear_faults, o_status_clr} <= 2'h0;
	endtask
endmodule

// ### bench/tb_top.sv
// Self-checking testbench of the over-voltage fault response controller.
`timescale 1ns/1ps
module tb_top;
	logic        i_clk = 1'b0;
	logic        i_rstn = 1'b0;
	logic        ctrl_on = 1'b1;
	logic [15:0] vout = 16'h0000;
	logic        ext_sd = 1'b0;
	logic [15:0] ov_limit = 16'h8000;
	logic        wr, clrf, sclr, tick, out_en, ov_flag, en_prev = 1'b0;
	logic [7:0]  addr, wdata, rdata;
	logic [2:0]  state;
	logic [31:0] seed = 32'h4d79;
	logic [10:0] q[$];
	logic [10:0] exp;
	logic [7:0]  obs[6];
	int          fail_count = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          attempts = 0;

	initial forever #25 i_clk = ~i_clk;

	ovf_host_model #(.TICK_DIV(2)) ovf_host_model_i (.i_clk(i_clk), .o_wr(wr),
		.o_addr(addr), .o_wdata(wdata), .o_clear_faults(clrf), .o_status_clr(sclr),
		.o_tick(tick));

	ovf_fault_ctrl ovf_fault_ctrl_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_reg_wr(wr),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
		.i_clear_faults(clrf), .i_status_clr(sclr), .i_ctrl_on(ctrl_on),
		.i_ext_shutdown(ext_sd), .i_vout(vout), .i_ov_fault_threshold(ov_limit),
		.i_unit_tick(tick), .o_out_en(out_en), .o_ov_fault(ov_flag), .o_state(state));

	always_comb obs = '{rdata, {7'h0, out_en}, {7'h0, ov_flag}, {5'h0, state},
		8'(attempts), {7'h0, attempts > 6}};

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		samples_checked++;
		if (seen !== want) begin
			fail_count++;
			$display("Error at %0t: seen 0x%0h expected 0x%0h", $time, seen, want);
		end
	endtask

	task automatic conclude();
		$display("Counts: %0d compared, %0d mismatched", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Kinds: 0 read data, 1 enable, 2 flag, 3 state, 4 attempts, 5 attempts above six.
	task automatic note(input logic [2:0] k, input logic [7:0] v);
		q.push_back({k, v});
		@(negedge i_clk);
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge i_clk);
	endtask

	// Values above the limit are forced by the top bit plus one, so they never equal it.
	task automatic vset(input bit ov);
		seed = xs(seed);
		vout <= ov ? (16'h8001 | seed[15:0]) : {1'b0, seed[14:0]};
	endtask

	task automatic cfg(input logic [7:0] v);
		ovf_host_model_i.wr(8'h41, v);
		step(1);
	endtask

	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		en_prev <= out_en;
		if (out_en && !en_prev)
			attempts <= attempts + 1;
		if (q.size() != 0) begin
			exp = q.pop_front();
			check(obs[exp[10:8]], exp[7:0]);
		end
		if (cycles == 3000) begin
			fail_count++;
			conclude();
		end
	end

	initial begin
		step(16);
		i_rstn <= 1'b1;
		step(4);
		ovf_host_model_i.wr(8'h33, 8'hff);
		note(0, 8'h00);
		ovf_host_model_i.rd(8'h41);
		note(0, 8'h80);
		seed = xs(seed);
		cfg(seed[7:0]);
		note(0, seed[7:0]);
		$display("Register test done");
		cfg(8'h00);
		vset(1);
		step(3);
		note(1, 8'h01);
		note(2, 8'h01);
		vset(0);
		ovf_host_model_i.clr(1);
		step(1);
		note(2, 8'h00);
		// A level equal to the limit is no fault; one step above it is.
		seed = xs(seed);
		ov_limit <= {1'b0, seed[14:0]};
		vout <= {1'b0, seed[14:0]};
		step(3);
		note(2, 8'h00);
		vout <= {1'b0, seed[14:0]} + 16'h0001;
		step(2);
		note(2, 8'h01);
		ov_limit <= 16'h8000;
		vout <= 16'h0000;
		ovf_host_model_i.clr(0);
		step(1);
		note(2, 8'h00);
		cfg(8'hc0);
		vset(1);
		step(1);
		note(1, 8'h00);
		vset(0);
		step(3);
		note(1, 8'h01);
		cfg(8'h80);
		vset(1);
		step(1);
		note(1, 8'h00);
		step(20);
		note(3, 8'h06);
		vset(0);
		step(20);
		note(1, 8'h00);
		i_rstn <= 1'b0;
		step(2);
		i_rstn <= 1'b1;
		step(4);
		note(1, 8'h01);
		$display("Response code test done");
		cfg(8'h43);
		vset(1);
		step(3);
		note(1, 8'h01);
		note(3, 8'h01);
		step(6);
		note(3, 8'h01);
		step(12);
		note(3, 8'h06);
		vset(0);
		ovf_host_model_i.clr(0);
		step(3);
		$display("Delay test done");
		for (int c = 1; c < 8; c++) begin
			ctrl_on <= 1'b0;
			step(4);
			cfg({2'b10, c[2:0], 2'h0, c[0]});
			ctrl_on <= 1'b1;
			step(5);
			attempts = 0;
			vset(1);
			step(120);
			if (c < 7) begin
				note(4, 8'(c));
				note(3, 8'h06);
			end else begin
				note(5, 8'h01);
				ctrl_on <= 1'b0;
				step(3);
				note(1, 8'h00);
				note(3, 8'h00);
				ctrl_on <= 1'b1;
				step(4);
				ext_sd <= 1'b1;
				step(2);
				note(3, 8'h06);
				note(1, 8'h00);
				ext_sd <= 1'b0;
				step(4);
				note(3, 8'h06);
			end
			vset(0);
			ovf_host_model_i.clr(c[0]);
			step(2);
		end
		$display("Retry count test done");
		step(2);
		conclude();
	end
endmodule
